// [rtl/tqf_pkg.sv]
// Purpose: shared constants and types for the trigger qualifier
// Assumes: 100 MHz sampling clock, APB register access
// Notes: all counts are in clock cycles unless named otherwise
package tqf_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] PAT_ADDR = 12'h004;
  localparam logic [11:0] HOLD_ADDR = 12'h008;
  localparam logic [11:0] WIDTH_ADDR = 12'h00C;
  localparam logic [11:0] QDEL_ADDR = 12'h010;
  localparam logic [11:0] VLINE_ADDR = 12'h014;
  localparam logic [11:0] CMD_ADDR = 12'h018;
  localparam logic [11:0] STAT_ADDR = 12'h01C;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] PAT_RST = 32'h0000_0000;
  localparam logic [31:0] HOLD_RST = 32'h0000_0000;
  localparam logic [31:0] WIDTH_RST = 32'h0000_0000;
  localparam logic [31:0] QDEL_RST = 32'h0000_0000;
  localparam logic [31:0] VLINE_RST = 32'h0000_0000;

  // Control field positions
  localparam int SRC_LSB = 0;
  localparam int SLOPE_LSB = 3;
  localparam int ARM_LSB = 6;
  localparam int TYPE_LSB = 8;
  localparam int PAT_SEL_BIT = 11;
  localparam int PAT_EXIT_BIT = 12;
  localparam int QUAL_ABS_BIT = 13;
  localparam int HO_EVT_BIT = 14;
  localparam int QD_EVT_BIT = 15;
  localparam int VID_ONE_BIT = 16;
  localparam int FLD_TOT_LSB = 17;
  localparam int FLD_IDX_LSB = 19;
  localparam int SEG_SEL_LSB = 22;

  // Command bits, status fields
  localparam int CMD_ARM_BIT = 0;
  localparam int CMD_CLR_BIT = 1;
  localparam int ST_ARMED_BIT = 0;
  localparam int ST_NOTRIG_BIT = 1;
  localparam int ST_SWEEP_BIT = 2;
  localparam int ST_SEG_LSB = 3;
  localparam int ST_FLD_LSB = 11;

  // Source codes
  localparam logic [2:0] SRC_CH1 = 3'h0;
  localparam logic [2:0] SRC_CH2 = 3'h1;
  localparam logic [2:0] SRC_LINE = 3'h2;
  localparam logic [2:0] SRC_EXT = 3'h3;
  localparam logic [2:0] SRC_EXT10 = 3'h4;

  // Arming modes
  localparam logic [1:0] ARM_AUTO = 2'h0;
  localparam logic [1:0] ARM_NORMAL = 2'h1;
  localparam logic [1:0] ARM_SINGLE = 2'h2;
  localparam logic [1:0] ARM_SEQ = 2'h3;

  // Trigger types
  localparam logic [2:0] TT_EDGE = 3'h0;
  localparam logic [2:0] TT_PW_LT = 3'h1;
  localparam logic [2:0] TT_PW_GT = 3'h2;
  localparam logic [2:0] TT_IV_LT = 3'h3;
  localparam logic [2:0] TT_IV_GT = 3'h4;
  localparam logic [2:0] TT_STATEQ = 3'h5;
  localparam logic [2:0] TT_TEQ = 3'h6;
  localparam logic [2:0] TT_VIDEO = 3'h7;

  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_PS = 10000;
  localparam int HO_MIN_PS = 25000;
  localparam int PW_MIN_PS = 2500;
  localparam int IVS_MIN_PS = 10000;
  localparam int IVL_MIN_PS = 25000;
  localparam int PORCH_PS = 1500000;
  localparam int AUTO_PERIOD_MS = 50;
  localparam int NOTRIG_MS = 1000;
  localparam logic [31:0] HO_MIN_CYC = 32'((HO_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [31:0] PW_MIN_CYC = 32'((PW_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [31:0] IVS_MIN_CYC = 32'((IVS_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [31:0] IVL_MIN_CYC = 32'((IVL_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [15:0] PORCH_CYC = 16'(PORCH_PS / CLK_PERIOD_PS);
  localparam longint AUTO_CYC = longint'(AUTO_PERIOD_MS) * 1000000000 / CLK_PERIOD_PS;
  localparam longint NOTRIG_CYC = longint'(NOTRIG_MS) * 1000000000 / CLK_PERIOD_PS;

  ////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic first_channel_src;
    logic second_channel_src;
    logic ext;
    logic ext_att;
    logic line;
    logic vid_hsync;
    logic vid_field;
    logic vid_odd;
  } tqf_in_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARMED = 3'b010,
    ST_SWEEP = 3'b100
  } tqf_arm_t;

endpackage

// [rtl/tqf_trigger_qualifier.sv]
// Purpose: digital trigger qualification for a two-channel sampler
// Assumes: comparator and sync inputs arrive as levels; APB slave
// Notes: acq_done marks the end of each acquisition sweep
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ns
module tqf_trigger_qualifier #(
  parameter longint AUTO_CYC = tqf_pkg::AUTO_CYC,
  parameter longint NOTRIG_CYC = tqf_pkg::NOTRIG_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire tqf_pkg::tqf_in_t cmp_in,
  input wire logic acq_done,
  output logic trig_out,
  output logic armed_out,
  output logic no_trig_out,
  output logic [7:0] seg_index_out
);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0] ctrl_reg, pat_reg, hold_reg, width_reg, qdel_reg, vline_reg;
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg;
  logic wr_en, arm_req, clr_req, mapped;
  logic [31:0] rd_mux, status;

  logic [2:0] src;
  logic [2:0] slope;
  logic [1:0] arm_mode;
  logic [2:0] ttype;
  logic [1:0] fld_tot;
  logic [2:0] fld_idx, seg_sel;
  assign src = ctrl_reg[tqf_pkg::SRC_LSB +: 3];
  assign slope = ctrl_reg[tqf_pkg::SLOPE_LSB +: 3];
  assign arm_mode = ctrl_reg[tqf_pkg::ARM_LSB +: 2];
  assign ttype = ctrl_reg[tqf_pkg::TYPE_LSB +: 3];
  assign fld_tot = ctrl_reg[tqf_pkg::FLD_TOT_LSB +: 2];
  assign fld_idx = ctrl_reg[tqf_pkg::FLD_IDX_LSB +: 3];
  assign seg_sel = ctrl_reg[tqf_pkg::SEG_SEL_LSB +: 3];

  assign wr_en = psel & penable & pready_reg & pwrite;
  assign arm_req = wr_en & (paddr == tqf_pkg::CMD_ADDR) & pwdata[tqf_pkg::CMD_ARM_BIT];
  assign clr_req = wr_en & (paddr == tqf_pkg::CMD_ADDR) & pwdata[tqf_pkg::CMD_CLR_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers and edge history
  tqf_pkg::tqf_in_t sync1_reg, sync2_reg, prev_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end else begin
      sync1_reg <= cmp_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // Level of each source, polarised except line, indexed by source code
  function automatic logic [4:0] polar(tqf_pkg::tqf_in_t v, logic [2:0] s);
    polar = {v.ext_att ^ s[2], v.ext ^ s[2], v.line, v.second_channel_src ^ s[1],
             v.first_channel_src ^ s[0]};
  endfunction

  // Three-term pattern; excluded terms count as ignored
  function automatic logic pmatch(logic [5:0] p, logic [2:0] lv, logic [2:0] ex);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 3; i++) begin
      if (!ex[i] && p[2*i +: 2] == 2'h1 && lv[i]) begin
        ok = 1'b0;
      end
      if (!ex[i] && p[2*i +: 2] == 2'h2 && !lv[i]) begin
        ok = 1'b0;
      end
    end
    pmatch = ok;
  endfunction

  logic [4:0] pol_cur, pol_old;
  logic src_lvl, src_old, src_rise;
  logic [2:0] raw_cur, raw_old, excl;
  logic pat_cur, pat_old, pat_exit;
  logic sig_cur, sig_old, sig_rise, sig_fall;

  assign pol_cur = polar(sync2_reg, slope);
  assign pol_old = polar(prev_reg, slope);
  assign src_lvl = (src > tqf_pkg::SRC_EXT10) ? pol_cur[0] : pol_cur[src];
  assign src_old = (src > tqf_pkg::SRC_EXT10) ? pol_old[0] : pol_old[src];
  assign src_rise = src_lvl & ~src_old;

  assign raw_cur = {sync2_reg.ext, sync2_reg.second_channel_src, sync2_reg.first_channel_src};
  assign raw_old = {prev_reg.ext, prev_reg.second_channel_src, prev_reg.first_channel_src};
  assign pat_exit = ctrl_reg[tqf_pkg::PAT_EXIT_BIT];

  assign pat_cur = pmatch(pat_reg[5:0], raw_cur, 3'h0) ^ pat_exit;
  assign pat_old = pmatch(pat_reg[5:0], raw_old, 3'h0) ^ pat_exit;

  // pattern drives width and hold-off logic
  assign sig_cur = ctrl_reg[tqf_pkg::PAT_SEL_BIT] ? pat_cur : src_lvl;
  assign sig_old = ctrl_reg[tqf_pkg::PAT_SEL_BIT] ? pat_old : src_old;
  assign sig_rise = sig_cur & ~sig_old;
  assign sig_fall = ~sig_cur & sig_old;

  ////////////////////////////////////////////////////////////////////////
  // Width and interval measurement
  logic [31:0] meas_reg, lim;
  logic seen_reg;

  always_comb begin
    case (ttype)
      tqf_pkg::TT_PW_LT, tqf_pkg::TT_PW_GT: lim = (width_reg < tqf_pkg::PW_MIN_CYC) ?
                                                    tqf_pkg::PW_MIN_CYC : width_reg;
      tqf_pkg::TT_IV_LT: lim = (width_reg < tqf_pkg::IVS_MIN_CYC) ? tqf_pkg::IVS_MIN_CYC : width_reg;
      default: lim = (width_reg < tqf_pkg::IVL_MIN_CYC) ? tqf_pkg::IVL_MIN_CYC : width_reg;
    endcase
  end

  // Counter restarts on each opening edge and saturates
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meas_reg <= 32'h0000_0000;
      seen_reg <= 1'b0;
    end else if (sig_rise) begin
      meas_reg <= 32'h0000_0001;
      seen_reg <= 1'b1;
    end else if (meas_reg != 32'hFFFF_FFFF) begin
      meas_reg <= meas_reg + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State and time/event qualification
  logic [31:0] qd_reg;
  logic wait_reg, qual_cur, qual_old, qual_rise, teq_start, q_load, q_active, q_fire;

  always_comb begin
    case (src)
      tqf_pkg::SRC_CH1: excl = 3'h1;
      tqf_pkg::SRC_CH2: excl = 3'h2;
      tqf_pkg::SRC_EXT, tqf_pkg::SRC_EXT10: excl = 3'h4;
      default: excl = 3'h0;
    endcase
  end

  assign qual_cur = pmatch(pat_reg[5:0], raw_cur, excl) ^ ctrl_reg[tqf_pkg::QUAL_ABS_BIT];
  assign qual_old = pmatch(pat_reg[5:0], raw_old, excl) ^ ctrl_reg[tqf_pkg::QUAL_ABS_BIT];
  assign qual_rise = qual_cur & ~qual_old;
  assign teq_start = pat_cur & ~pat_old;
  assign q_load = (ttype == tqf_pkg::TT_STATEQ) ? qual_rise : teq_start;
  assign q_active = (ttype == tqf_pkg::TT_STATEQ) ? qual_cur : wait_reg;
  assign q_fire = q_active & src_rise & (q_load ? (qdel_reg == 32'h0000_0000) :
                                                  (qd_reg == 32'h0000_0000));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      qd_reg <= 32'h0000_0000;
    end else if (q_load) begin
      qd_reg <= qdel_reg;
    end else if (qd_reg != 32'h0000_0000 && (!ctrl_reg[tqf_pkg::QD_EVT_BIT] || src_rise)) begin
      qd_reg <= qd_reg - 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_reg <= 1'b0;
    end else if (teq_start) begin
      wait_reg <= 1'b1;
    end else if (q_fire) begin
      wait_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Video line and field tracking
  logic [15:0] since_reg, lper_reg, line_reg;
  logic [2:0] fld_reg, fld_mask, fld_want, fld_inc;
  logic h_rise, f_rise, v_fire;

  assign h_rise = sync2_reg.vid_hsync & ~prev_reg.vid_hsync;
  assign f_rise = sync2_reg.vid_field & ~prev_reg.vid_field;
  // field total of 1, 2, 4 or 8
  assign fld_mask = 3'((4'h1 << fld_tot) - 4'h1);
  assign fld_want = ((fld_idx == 3'h0) ? 3'h0 : fld_idx - 3'h1) & fld_mask;
  assign fld_inc = fld_reg + 3'h1;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      since_reg <= 16'h0000;
      lper_reg <= 16'h0000;
    end else if (h_rise) begin
      since_reg <= 16'h0001;
      lper_reg <= since_reg;
    end else if (since_reg != 16'hFFFF) begin
      since_reg <= since_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      line_reg <= 16'h0000;
    end else if (f_rise) begin
      line_reg <= 16'h0000;
    end else if (h_rise) begin
      line_reg <= line_reg + 16'h0001;
    end
  end

  // parity from separator, upper bits relative
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fld_reg <= 3'h0;
    end else if (f_rise) begin
      fld_reg <= {fld_inc[2:1], ~sync2_reg.vid_odd} & fld_mask;
    end
  end

  // front porch point, any or chosen line
  assign v_fire = (lper_reg > tqf_pkg::PORCH_CYC) && (since_reg == lper_reg - tqf_pkg::PORCH_CYC) &&
                  (!ctrl_reg[tqf_pkg::VID_ONE_BIT] ||
                   (line_reg == vline_reg[15:0] && fld_reg == fld_want));

  ////////////////////////////////////////////////////////////////////////
  // Trigger selection and hold-off
  logic raw_fire, accept, force_trig;
  logic [31:0] ho_reg, ho_load;

  always_comb begin
    case (ttype)
      tqf_pkg::TT_EDGE: raw_fire = sig_rise;
      tqf_pkg::TT_PW_LT: raw_fire = sig_fall & seen_reg & (meas_reg < lim);
      tqf_pkg::TT_PW_GT: raw_fire = sig_fall & seen_reg & (meas_reg > lim);
      tqf_pkg::TT_IV_LT: raw_fire = sig_rise & seen_reg & (meas_reg < lim);
      tqf_pkg::TT_IV_GT: raw_fire = sig_rise & seen_reg & (meas_reg > lim);
      tqf_pkg::TT_STATEQ, tqf_pkg::TT_TEQ: raw_fire = q_fire;
      tqf_pkg::TT_VIDEO: raw_fire = v_fire;
      default: raw_fire = 1'b0;
    endcase
  end

  tqf_pkg::tqf_arm_t state_reg;
  // Auto trigger bypasses hold-off so the display never freezes
  assign accept = (state_reg == tqf_pkg::ST_ARMED) & ((raw_fire & (ho_reg == 32'h0000_0000)) | force_trig);
  assign ho_load = (!ctrl_reg[tqf_pkg::HO_EVT_BIT] && hold_reg < tqf_pkg::HO_MIN_CYC) ?
                   tqf_pkg::HO_MIN_CYC : hold_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ho_reg <= 32'h0000_0000;
    end else if (accept) begin
      ho_reg <= ho_load;
    end else if (ho_reg != 32'h0000_0000 && (!ctrl_reg[tqf_pkg::HO_EVT_BIT] || sig_rise)) begin
      ho_reg <= ho_reg - 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Arming
  logic [7:0] seg_reg, seg_total;
  logic [31:0] auto_reg, nt_reg;
  logic no_trig_reg, trig_reg;

  always_comb begin
    case (seg_sel)
      3'h1: seg_total = 8'h05;
      3'h2: seg_total = 8'h0A;
      3'h3: seg_total = 8'h14;
      3'h4: seg_total = 8'h32;
      3'h5: seg_total = 8'h64;
      3'h6: seg_total = 8'hC8;
      default: seg_total = 8'h02;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= tqf_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        tqf_pkg::ST_IDLE: begin
          if (arm_req) begin
            state_reg <= tqf_pkg::ST_ARMED;
          end
        end
        tqf_pkg::ST_ARMED: begin
          if (accept) begin
            state_reg <= tqf_pkg::ST_SWEEP;
          end
        end
        tqf_pkg::ST_SWEEP: begin
          if (acq_done) begin
            if (arm_mode == tqf_pkg::ARM_SINGLE) begin
              state_reg <= tqf_pkg::ST_IDLE;
            end else if (arm_mode == tqf_pkg::ARM_SEQ && seg_reg + 8'h01 >= seg_total) begin
              state_reg <= tqf_pkg::ST_IDLE;
            end else begin
              state_reg <= tqf_pkg::ST_ARMED;
            end
          end
        end
        default: state_reg <= tqf_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      seg_reg <= 8'h00;
    end else if (state_reg == tqf_pkg::ST_IDLE && arm_req) begin
      seg_reg <= 8'h00;
    end else if (state_reg == tqf_pkg::ST_SWEEP && acq_done && arm_mode == tqf_pkg::ARM_SEQ &&
                 seg_reg + 8'h01 < seg_total) begin
      seg_reg <= seg_reg + 8'h01;
    end
  end

  assign force_trig = (arm_mode == tqf_pkg::ARM_AUTO) && (auto_reg >= 32'(AUTO_CYC - 1));
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      auto_reg <= 32'h0000_0000;
    end else if (state_reg != tqf_pkg::ST_ARMED || accept) begin
      auto_reg <= 32'h0000_0000;
    end else begin
      auto_reg <= auto_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nt_reg <= 32'h0000_0000;
      no_trig_reg <= 1'b0;
    end else begin
      if (state_reg != tqf_pkg::ST_ARMED || accept || arm_mode != tqf_pkg::ARM_NORMAL) begin
        nt_reg <= 32'h0000_0000;
      end else if (nt_reg != 32'hFFFF_FFFF) begin
        nt_reg <= nt_reg + 32'h0000_0001;
      end
      if (arm_mode == tqf_pkg::ARM_NORMAL && nt_reg == 32'(NOTRIG_CYC - 1) && !accept) begin
        no_trig_reg <= 1'b1;
      end else if (clr_req || accept) begin
        no_trig_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trig_reg <= 1'b0;
    end else begin
      trig_reg <= accept;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave: answers one cycle after setup
  assign status = {18'h00000, fld_reg, seg_reg, state_reg == tqf_pkg::ST_SWEEP, no_trig_reg,
                   state_reg == tqf_pkg::ST_ARMED};

  always_comb begin
    mapped = 1'b1;
    case (paddr)
      tqf_pkg::CTRL_ADDR: rd_mux = ctrl_reg;
      tqf_pkg::PAT_ADDR: rd_mux = pat_reg;
      tqf_pkg::HOLD_ADDR: rd_mux = hold_reg;
      tqf_pkg::WIDTH_ADDR: rd_mux = width_reg;
      tqf_pkg::QDEL_ADDR: rd_mux = qdel_reg;
      tqf_pkg::VLINE_ADDR: rd_mux = vline_reg;
      tqf_pkg::CMD_ADDR: rd_mux = 32'h0000_0000;
      tqf_pkg::STAT_ADDR: rd_mux = status;
      default: begin
        rd_mux = 32'h0000_0000;
        mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= psel & ~penable;
      pslverr_reg <= psel & ~penable & ~mapped;
      prdata_reg <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // Status address is read-only; writes there are dropped
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= tqf_pkg::CTRL_RST;
      pat_reg <= tqf_pkg::PAT_RST;
      hold_reg <= tqf_pkg::HOLD_RST;
      width_reg <= tqf_pkg::WIDTH_RST;
      qdel_reg <= tqf_pkg::QDEL_RST;
      vline_reg <= tqf_pkg::VLINE_RST;
    end else if (wr_en) begin
      case (paddr)
        tqf_pkg::CTRL_ADDR: ctrl_reg <= {7'h00, pwdata[24:0]};
        tqf_pkg::PAT_ADDR: pat_reg <= {26'h0000000, pwdata[5:0]};
        tqf_pkg::HOLD_ADDR: hold_reg <= pwdata;
        tqf_pkg::WIDTH_ADDR: width_reg <= pwdata;
        tqf_pkg::QDEL_ADDR: qdel_reg <= pwdata;
        tqf_pkg::VLINE_ADDR: vline_reg <= {16'h0000, pwdata[15:0]};
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign trig_out = trig_reg;
  assign armed_out = state_reg[1];
  assign no_trig_out = no_trig_reg;
  assign seg_index_out = seg_reg;

endmodule

// [tb/tqf_checker.sv]
// Purpose: port-level checks for the trigger qualifier
// Assumes: one clock, asynchronous active-low reset
// Notes: bound from the bench top file
`timescale 1ns/1ns
module tqf_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic acq_done,
  input wire logic trig_out,
  input wire logic armed_out,
  input wire logic no_trig_out,
  input wire logic [7:0] seg_index_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire cmd_wr = psel && penable && pwrite && pready && (paddr == tqf_pkg::CMD_ADDR);
  ////////////////////////////////////////////////////////////////////////
  AST_PREADY_ACC: assert property (psel && !penable |=> pready) else $error("no ready"); // APB
  AST_RST_CLEAR: assert property (disable iff (1'b0) !resetn |-> !trig_out && !armed_out && !no_trig_out) else $error("rst");
  AST_TRIG_PULSE: assert property (trig_out |=> !trig_out) else $error("trig too long");
  AST_TRIG_DISARM: assert property (trig_out |-> !armed_out) else $error("armed at trig");
  AST_TRIG_ARMED: assert property (trig_out |-> $past(armed_out)) else $error("trig unarmed");
  AST_ARM_CAUSE: assert property ($rose(armed_out) |-> $past(acq_done) || $past(cmd_wr)) else $error("arm");
  AST_SEG_RANGE: assert property (seg_index_out < 8'hC8) else $error("seg range");
  AST_SEG_STEP: assert property ($changed(seg_index_out) |-> seg_index_out == 8'h00 ||
    seg_index_out == $past(seg_index_out) + 8'h01) else $error("seg step");
  // Main scenarios
  cover property (trig_out);
  cover property ($rose(no_trig_out));
  cover property (seg_index_out == 8'h01);
endmodule

// [tb/tqf_analog_model.sv]
// Purpose: comparator front end facing the trigger qualifier
// Assumes: comparator outputs are plain levels
// Notes: video and line comparators rest low here
`timescale 1ns/1ns
module tqf_analog_model (
  input wire logic clk,
  output tqf_pkg::tqf_in_t cmp_in
);
  initial cmp_in = '0;
  // Changes land just after an edge, like a real async level would settle
  task automatic put(input tqf_pkg::tqf_in_t v, input int hold);
    @(posedge clk);
    cmp_in <= v;
    repeat (hold) @(posedge clk);
  endtask
endmodule

// [tb/tqf_trigger_qualifier_tb.sv]
// Purpose: self-checking bench for the trigger qualifier
// Assumes: zero-wait APB slave, shortened auto and timeout counts
// Notes: trigger pulses are counted by a watcher, not polled
`timescale 1ns/1ns
module tqf_trigger_qualifier_tb;
  logic clk, resetn, psel, penable, pwrite, acq_done, pready, pslverr, trig_out, armed_out, no_trig_out, e, neg;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0] seg_index_out;
  tqf_pkg::tqf_in_t cmp_in;
  int fail_count = 0, checks_done = 0, cyc = 0, tcnt = 0, n0, k;
  int wd[7] = '{2, 12, 2, 12, 2, 12, 12};
  int ex[7] = '{1, 0, 0, 1, 1, 0, 1};
  tqf_trigger_qualifier #(.AUTO_CYC(50), .NOTRIG_CYC(100)) uut (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_in(cmp_in), .acq_done(acq_done), .trig_out(trig_out), .armed_out(armed_out),
    .no_trig_out(no_trig_out), .seg_index_out(seg_index_out));
  tqf_analog_model model (.clk(clk), .cmp_in(cmp_in));
  always #5 clk = ~clk;
  always @(posedge clk) tcnt <= tcnt + int'(trig_out === 1'b1);
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic arm(input logic [31:0] c);
    apb(1'b1, tqf_pkg::CTRL_ADDR, c);
    apb(1'b1, tqf_pkg::CMD_ADDR, 32'h00000001);
  endtask
  task automatic done_pulse;
    acq_done <= 1'b1;
    @(posedge clk);
    acq_done <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // Only first channel, second channel and external drive bits 7, 6, 5
  function automatic tqf_pkg::tqf_in_t mk(input int idx, input logic v);
    mk = tqf_pkg::tqf_in_t'({7'h00, v} << (7 - idx));
  endfunction
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    resetn = 1'b1;
    {psel, penable, pwrite, acq_done, paddr, pwdata} = '0;
    void'($urandom(2634));
    // Assert reset off time zero so every flop sees a clean falling edge
    #1 resetn = 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 32; a += 4) begin
      apb(1'b0, 12'(a), 32'h00000000);
      chk(r, 32'h00000000);
    end
    apb(1'b0, 12'h0FC, 32'h00000000);
    chk(e, 32'h00000001);
    for (int i = 0; i < 6; i++) begin
      k = i % 3;
      neg = 1'($urandom_range(0, 1));
      model.put(mk(k, neg), 4);
      arm({24'h000000, tqf_pkg::ARM_SINGLE, 3'(neg) << k, (k == 2) ? tqf_pkg::SRC_EXT : 3'(k)});
      n0 = tcnt;
      model.put(mk(k, !neg), 10);
      chk(tcnt - n0, 1);
      chk(armed_out, 0);
      done_pulse();
      model.put(mk(k, neg), 3);
      model.put(mk(k, !neg), 10);
      chk(tcnt - n0, 1);
    end
    apb(1'b1, tqf_pkg::WIDTH_ADDR, 32'h00000006);
    for (int j = 0; j < 7; j++) begin
      model.put('0, 16);
      arm({21'h000000, 3'(j / 2 + 1), tqf_pkg::ARM_SINGLE, 6'h00});
      n0 = tcnt;
      if (j < 4) model.put(mk(0, 1'b1), wd[j]);
      else begin
        model.put(mk(0, 1'b1), 1);
        model.put('0, wd[j] - 1);
        model.put(mk(0, 1'b1), 1);
      end
      model.put('0, 12);
      chk(tcnt - n0, ex[j]);
      done_pulse();
    end
    arm({24'h000000, tqf_pkg::ARM_AUTO, 6'h00});
    n0 = tcnt;
    repeat (80) @(posedge clk);
    chk(tcnt - n0, 1);
    done_pulse();
    chk(armed_out, 1);
    arm({24'h000000, tqf_pkg::ARM_NORMAL, 6'h00});
    repeat (150) @(posedge clk);
    chk(no_trig_out, 1);
    apb(1'b1, tqf_pkg::CMD_ADDR, 32'h00000002);
    apb(1'b0, tqf_pkg::STAT_ADDR, 32'h00000000);
    chk(r[tqf_pkg::ST_NOTRIG_BIT], 0);
    arm({24'h000000, tqf_pkg::ARM_SEQ, 6'h00});
    for (int s = 0; s < 2; s++) begin
      model.put(mk(0, 1'b1), 1);
      model.put('0, 10);
      done_pulse();
      chk(armed_out, 32'(s == 0));
      if (s == 0) chk(seg_index_out, 1);
    end
    // Bi-level: one signal on both channels, upper comparator low and lower high means in band
    apb(1'b1, tqf_pkg::PAT_ADDR, 32'h00000009);
    for (int b = 0; b < 2; b++) begin
      model.put(mk(1, 1'b1), 6);
      arm(32'h00001880);
      n0 = tcnt;
      model.put(tqf_pkg::tqf_in_t'((b == 0) ? 8'hC0 : 8'h00), 10);
      chk(tcnt - n0, 1);
      done_pulse();
    end
    // Event hold-off: two edges after each trigger are ignored
    apb(1'b1, tqf_pkg::HOLD_ADDR, 32'h00000002);
    arm(32'h00004040);
    n0 = tcnt;
    repeat (4) begin
      model.put(mk(0, 1'b1), 1);
      model.put('0, 8);
      done_pulse();
    end
    chk(tcnt - n0, 2);
    end_of_test();
  end
endmodule
bind tqf_trigger_qualifier tqf_checker chk_i (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .acq_done(acq_done), .trig_out(trig_out),
  .armed_out(armed_out), .no_trig_out(no_trig_out), .seg_index_out(seg_index_out));
